//--- hw/sgp_pkg.sv
// register map, reset values and field layout of the global priority/forwarding bank
package sgp_pkg;
    // register offsets on the management port
    localparam logic [7:0] REG_REMAP_LOW = 8'h0c;
    localparam logic [7:0] REG_REMAP_HIGH = 8'h0d;
    localparam logic [7:0] REG_FWD_CTRL = 8'h0e;
    localparam logic [7:0] REG_PHY_ADDR = 8'h0f;
    // reset values
    localparam logic [7:0] RST_REMAP_LOW = 8'h50;
    localparam logic [7:0] RST_REMAP_HIGH = 8'hfa;
    localparam logic [7:0] RST_FWD_CTRL = 8'h47;
    localparam logic [7:0] RST_PHY_ADDR = 8'h08;
    // writable bits; the rest hold their reset value
    localparam logic [7:0] WMASK_FWD_CTRL = 8'hc7;
    localparam logic [7:0] WMASK_PHY_ADDR = 8'hf8;
    // field positions
    localparam int FWD_EN_BIT = 7;
    localparam int DRIVE_BIT = 6;
    localparam int FWD_MASK_MSB = 2;
    localparam int PHY_LSB = 3;
    localparam int PHY_MSB = 7;
    // unusable port 1 phy address codes, port 2 address step and unmapped read data
    localparam logic [4:0] PHY_BAD_LOW = 5'h00;
    localparam logic [4:0] PHY_BAD_HI0 = 5'h1e;
    localparam logic [4:0] PHY_BAD_HI1 = 5'h1f;
    localparam logic [4:0] PHY2_STEP = 5'h01;
    localparam logic [7:0] RDATA_UNMAPPED = 8'h00;
endpackage

//--- hw/sgp_global_cfg.sv
// global 802.1p remap, unknown-destination forwarding, pad drive and phy address bank
`timescale 1ns/1ns
module sgp_global_cfg (
    input wire logic core_clk_in,
    input wire logic srst_in,
    // management register port
    input wire logic [7:0] reg_addr_in,
    input wire logic reg_wr_in,
    input wire logic reg_rd_in,
    input wire logic [7:0] reg_wdata_in,
    output logic [7:0] reg_rdata_out,
    output logic reg_rvalid_out,
    // classification request from the ingress path
    input wire logic cls_valid_in,
    input wire logic [2:0] cls_tag_in,
    input wire logic cls_en_in,
    input wire logic [1:0] cls_port_prio_in,
    output logic cls_valid_out,
    output logic [1:0] cls_prio_out,
    // destination lookup miss
    input wire logic miss_valid_in,
    output logic fwd_valid_out,
    output logic fwd_override_out,
    output logic [2:0] fwd_ports_out,
    // phy management address match
    input wire logic miim_req_in,
    input wire logic [4:0] miim_addr_in,
    output logic miim_ack_out,
    output logic [1:0] miim_sel_out,
    // static settings
    output logic drive_strong_out,
    output logic [4:0] phy1_addr_out,
    output logic [4:0] phy2_addr_out
);

    // two-bit priority for a tag from the concatenated remap registers
    function automatic logic [1:0] remap_lookup(input logic [2:0] tag, input logic [7:0] low,
                                                input logic [7:0] high);
        logic [15:0] all;
        all = {high, low};
        remap_lookup = all[{tag, 1'b0} +: 2];
    endfunction

    function automatic logic phy_code_ok(input logic [4:0] code);
        phy_code_ok = (code != sgp_pkg::PHY_BAD_LOW) && (code != sgp_pkg::PHY_BAD_HI0)
                      && (code != sgp_pkg::PHY_BAD_HI1);
    endfunction

    logic [7:0] remap_low;
    logic [7:0] remap_high;
    logic [7:0] fwd_ctrl;
    logic [4:0] phy_field;
    logic [7:0] next_remap_low;
    logic [7:0] next_remap_high;
    logic [7:0] next_fwd_ctrl;
    logic [4:0] next_phy_field;
    logic [4:0] next_phy2;
    logic [7:0] next_rdata;
    logic [1:0] next_cls_prio;
    logic [2:0] next_fwd_ports;
    logic [1:0] next_miim_sel;

    // register writes; reserved bits are rebuilt from reset values so writes cannot reach them
    always_comb begin
        next_remap_low = remap_low;
        next_remap_high = remap_high;
        next_fwd_ctrl = fwd_ctrl;
        next_phy_field = phy_field;
        if (reg_wr_in) begin
            unique case (reg_addr_in)
                sgp_pkg::REG_REMAP_LOW: next_remap_low = reg_wdata_in;
                sgp_pkg::REG_REMAP_HIGH: next_remap_high = reg_wdata_in;
                sgp_pkg::REG_FWD_CTRL: begin
                    next_fwd_ctrl = (reg_wdata_in & sgp_pkg::WMASK_FWD_CTRL)
                                    | (sgp_pkg::RST_FWD_CTRL & ~sgp_pkg::WMASK_FWD_CTRL);
                end
                sgp_pkg::REG_PHY_ADDR: begin
                    // unusable codes are dropped so the pair of phy addresses stays valid
                    if (phy_code_ok(reg_wdata_in[sgp_pkg::PHY_MSB:sgp_pkg::PHY_LSB])) begin
                        next_phy_field = reg_wdata_in[sgp_pkg::PHY_MSB:sgp_pkg::PHY_LSB];
                    end
                end
                default: ;
            endcase
        end
        next_phy2 = next_phy_field + sgp_pkg::PHY2_STEP;
    end

    // read mux; unmapped offsets answer zero, and the last read data holds between reads
    always_comb begin
        next_rdata = reg_rdata_out;
        if (reg_rd_in) begin
            unique case (reg_addr_in)
                sgp_pkg::REG_REMAP_LOW: next_rdata = remap_low;
                sgp_pkg::REG_REMAP_HIGH: next_rdata = remap_high;
                sgp_pkg::REG_FWD_CTRL: next_rdata = fwd_ctrl;
                sgp_pkg::REG_PHY_ADDR: next_rdata = {phy_field, sgp_pkg::RST_PHY_ADDR[2:0]};
                default: next_rdata = sgp_pkg::RDATA_UNMAPPED;
            endcase
        end
    end

    // datapath answers use the settings as they stand, so a write lands on the next request
    always_comb begin
        next_cls_prio = cls_prio_out;
        next_fwd_ports = fwd_ports_out;
        next_miim_sel = miim_sel_out;
        if (cls_valid_in) begin
            if (cls_en_in) begin
                next_cls_prio = remap_lookup(cls_tag_in, remap_low, remap_high);
            end else begin
                next_cls_prio = cls_port_prio_in;
            end
        end
        if (miss_valid_in) begin
            if (fwd_ctrl[sgp_pkg::FWD_EN_BIT]) begin
                next_fwd_ports = fwd_ctrl[sgp_pkg::FWD_MASK_MSB:0];
            end else begin
                next_fwd_ports = 3'h0;
            end
        end
        if (miim_req_in) begin
            next_miim_sel = {miim_addr_in == phy2_addr_out, miim_addr_in == phy_field};
        end
    end

    // state and output registers
    always_ff @(posedge core_clk_in) begin
        if (srst_in) begin
            remap_low <= sgp_pkg::RST_REMAP_LOW;
            remap_high <= sgp_pkg::RST_REMAP_HIGH;
            fwd_ctrl <= sgp_pkg::RST_FWD_CTRL;
            phy_field <= sgp_pkg::RST_PHY_ADDR[sgp_pkg::PHY_MSB:sgp_pkg::PHY_LSB];
            phy2_addr_out <= sgp_pkg::RST_PHY_ADDR[sgp_pkg::PHY_MSB:sgp_pkg::PHY_LSB]
                             + sgp_pkg::PHY2_STEP;
            reg_rdata_out <= sgp_pkg::RDATA_UNMAPPED;
            reg_rvalid_out <= 1'b0;
            cls_valid_out <= 1'b0;
            cls_prio_out <= 2'h0;
            fwd_valid_out <= 1'b0;
            fwd_ports_out <= 3'h0;
            miim_ack_out <= 1'b0;
            miim_sel_out <= 2'h0;
        end else begin
            remap_low <= next_remap_low;
            remap_high <= next_remap_high;
            fwd_ctrl <= next_fwd_ctrl;
            phy_field <= next_phy_field;
            phy2_addr_out <= next_phy2;
            reg_rdata_out <= next_rdata;
            reg_rvalid_out <= reg_rd_in;
            cls_valid_out <= cls_valid_in;
            cls_prio_out <= next_cls_prio;
            fwd_valid_out <= miss_valid_in;
            fwd_ports_out <= next_fwd_ports;
            miim_ack_out <= miim_req_in;
            miim_sel_out <= next_miim_sel;
        end
    end

    // static settings come straight from the bank
    assign drive_strong_out = fwd_ctrl[sgp_pkg::DRIVE_BIT];
    assign fwd_override_out = fwd_ctrl[sgp_pkg::FWD_EN_BIT];
    assign phy1_addr_out = phy_field;

    default clocking cb @(posedge core_clk_in); endclocking
    default disable iff (srst_in);

    sequence s_cls_tag(logic [2:0] t);
        cls_valid_in && cls_en_in && cls_tag_in == t;
    endsequence
    sequence s_fwd_write;
        reg_wr_in && reg_addr_in == sgp_pkg::REG_FWD_CTRL && reg_wdata_in[7];
    endsequence
    sequence s_quiet_miss;
        miss_valid_in && !reg_wr_in;
    endsequence

    property p_remap_zero;
        s_cls_tag(3'h0) |=> cls_prio_out == $past(remap_low[1:0]);
    endproperty
    a_remap_zero: assert property (p_remap_zero) else $error("tag 0 remap wrong");

    property p_remap_seven;
        s_cls_tag(3'h7) |=> cls_prio_out == $past(remap_high[7:6]);
    endproperty
    a_remap_seven: assert property (p_remap_seven) else $error("tag 7 remap wrong");

    property p_remap_three;
        s_cls_tag(3'h3) |=> cls_valid_out && cls_prio_out == $past(remap_low[7:6]);
    endproperty
    a_remap_three: assert property (p_remap_three) else $error("tag 3 remap wrong");

    property p_fwd_disabled;
        miss_valid_in && !fwd_ctrl[7] |=> fwd_valid_out && fwd_ports_out == 3'h0;
    endproperty
    a_fwd_disabled: assert property (p_fwd_disabled) else $error("fwd ports while off");

    property p_fwd_new;
        s_fwd_write ##1 s_quiet_miss |=> fwd_ports_out == $past(reg_wdata_in[2:0], 2);
    endproperty
    a_fwd_new: assert property (p_fwd_new) else $error("fwd bitmap not applied");

    property p_drive;
        reg_wr_in && reg_addr_in == sgp_pkg::REG_FWD_CTRL |=>
            drive_strong_out == $past(reg_wdata_in[6]);
    endproperty
    a_drive: assert property (p_drive) else $error("drive bit not written");

    property p_phy_bad;
        reg_wr_in && reg_addr_in == sgp_pkg::REG_PHY_ADDR && !phy_code_ok(reg_wdata_in[7:3])
            |=> $stable(phy1_addr_out);
    endproperty
    a_phy_bad: assert property (p_phy_bad) else $error("bad phy code taken");

    property p_phy2;
        miim_req_in && miim_addr_in == phy1_addr_out + 5'h01 |=> miim_sel_out == 2'b10;
    endproperty
    a_phy2: assert property (p_phy2) else $error("port 2 phy not matched");

    property p_reserved;
        reg_rd_in && reg_addr_in == sgp_pkg::REG_FWD_CTRL |=>
            reg_rvalid_out && reg_rdata_out[5:3] == 3'h0;
    endproperty
    a_reserved: assert property (p_reserved) else $error("reserved bits not zero");

    property p_cls_off;
        cls_valid_in && !cls_en_in |=> cls_prio_out == $past(cls_port_prio_in);
    endproperty
    a_cls_off: assert property (p_cls_off) else $error("remap used while off");

endmodule // sgp_global_cfg

//--- verification/sgp_tb.sv
// self-checking bench for the global priority, forwarding and phy address bank
`timescale 1ns/1ns
`define CHK(a, b) begin comparisons++; if ((a) !== (b)) begin err_count++; \
    $display("Error at %0t: got %h expected %h", $time, a, b); end end
module testbench;
    logic core_clk_in = 1'b0;
    logic srst_in = 1'b1;
    logic [7:0] reg_addr_in = 8'h00;
    logic reg_wr_in = 1'b0;
    logic reg_rd_in = 1'b0;
    logic [7:0] reg_wdata_in = 8'h00;
    logic cls_valid_in = 1'b0;
    logic [2:0] cls_tag_in = 3'h0;
    logic cls_en_in = 1'b0;
    logic [1:0] cls_port_prio_in = 2'h0;
    logic miss_valid_in = 1'b0;
    logic miim_req_in = 1'b0;
    logic [4:0] miim_addr_in = 5'h00;
    logic [7:0] reg_rdata_out;
    logic reg_rvalid_out, cls_valid_out, fwd_valid_out, fwd_override_out, miim_ack_out;
    logic [1:0] cls_prio_out, miim_sel_out;
    logic [2:0] fwd_ports_out;
    logic drive_strong_out;
    logic [4:0] phy1_addr_out, phy2_addr_out;
    int err_count = 0;
    int comparisons = 0;
    sgp_global_cfg i_dut (.core_clk_in(core_clk_in), .srst_in(srst_in),
        .reg_addr_in(reg_addr_in), .reg_wr_in(reg_wr_in), .reg_rd_in(reg_rd_in),
        .reg_wdata_in(reg_wdata_in), .reg_rdata_out(reg_rdata_out),
        .reg_rvalid_out(reg_rvalid_out), .cls_valid_in(cls_valid_in), .cls_tag_in(cls_tag_in),
        .cls_en_in(cls_en_in), .cls_port_prio_in(cls_port_prio_in),
        .cls_valid_out(cls_valid_out), .cls_prio_out(cls_prio_out),
        .miss_valid_in(miss_valid_in), .fwd_valid_out(fwd_valid_out),
        .fwd_override_out(fwd_override_out), .fwd_ports_out(fwd_ports_out),
        .miim_req_in(miim_req_in), .miim_addr_in(miim_addr_in), .miim_ack_out(miim_ack_out),
        .miim_sel_out(miim_sel_out), .drive_strong_out(drive_strong_out),
        .phy1_addr_out(phy1_addr_out), .phy2_addr_out(phy2_addr_out));
    // 50 MHz core clock
    initial begin
        forever #10 core_clk_in = ~core_clk_in;
    end
    // expected priority from the two remap bytes, worked out independently
    function automatic logic [1:0] exp_prio(input logic [7:0] lo, input logic [7:0] hi,
                                            input int tag);
        return (tag < 4) ? lo[tag*2 +: 2] : hi[(tag-4)*2 +: 2];
    endfunction
    // one-cycle strobes, raised and dropped on falling edges so the rising edge sees them clean
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(negedge core_clk_in);
        reg_addr_in = a;
        reg_wdata_in = d;
        reg_wr_in = 1'b1;
        @(negedge core_clk_in);
        reg_wr_in = 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, input logic [7:0] exp);
        @(negedge core_clk_in);
        reg_addr_in = a;
        reg_rd_in = 1'b1;
        @(negedge core_clk_in);
        reg_rd_in = 1'b0;
        `CHK(reg_rvalid_out, 1'b1)
        `CHK(reg_rdata_out, exp)
    endtask
    task automatic cls(input int tag, input logic en, input logic [1:0] pp, input logic [1:0] e);
        @(negedge core_clk_in);
        cls_tag_in = tag[2:0];
        cls_en_in = en;
        cls_port_prio_in = pp;
        cls_valid_in = 1'b1;
        @(negedge core_clk_in);
        cls_valid_in = 1'b0;
        `CHK(cls_valid_out, 1'b1)
        `CHK(cls_prio_out, e)
    endtask
    task automatic miss(input logic ovr, input logic [2:0] ports);
        @(negedge core_clk_in);
        miss_valid_in = 1'b1;
        @(negedge core_clk_in);
        miss_valid_in = 1'b0;
        `CHK(fwd_valid_out, 1'b1)
        `CHK(fwd_override_out, ovr)
        `CHK(fwd_ports_out, ports)
    endtask
    task automatic miim(input logic [4:0] a, input logic [1:0] sel);
        @(negedge core_clk_in);
        miim_addr_in = a;
        miim_req_in = 1'b1;
        @(negedge core_clk_in);
        miim_req_in = 1'b0;
        `CHK(miim_ack_out, 1'b1)
        `CHK(miim_sel_out, sel)
    endtask
    // reset values of every register, an unmapped offset, and the static outputs
    task automatic t_reset;
        rd(sgp_pkg::REG_REMAP_LOW, 8'h50);
        rd(sgp_pkg::REG_REMAP_HIGH, 8'hfa);
        rd(sgp_pkg::REG_FWD_CTRL, 8'h47);
        rd(sgp_pkg::REG_PHY_ADDR, 8'h08);
        rd(8'h10, sgp_pkg::RDATA_UNMAPPED);
        `CHK({drive_strong_out, phy1_addr_out, phy2_addr_out}, {1'b1, 5'h01, 5'h02})
        $display("test reset done");
    endtask
    // every tag at reset mapping, then remapped with no reset between, then classification off
    task automatic t_remap;
        for (int t = 0; t < 8; t++) cls(t, 1'b1, 2'h3, exp_prio(8'h50, 8'hfa, t));
        wr(sgp_pkg::REG_REMAP_LOW, 8'h1b);
        wr(sgp_pkg::REG_REMAP_HIGH, 8'he4);
        for (int t = 0; t < 8; t++) cls(t, 1'b1, 2'h0, exp_prio(8'h1b, 8'he4, t));
        cls(7, 1'b0, 2'h2, 2'h2);
        rd(sgp_pkg::REG_REMAP_LOW, 8'h1b);
        $display("test remap done");
    endtask
    // unknown destination forwarding, bitmap, drive select and reserved bits
    task automatic t_fwd;
        miss(1'b0, 3'h0);
        wr(sgp_pkg::REG_FWD_CTRL, 8'hff);
        rd(sgp_pkg::REG_FWD_CTRL, 8'hc7);
        miss(1'b1, 3'h7);
        wr(sgp_pkg::REG_FWD_CTRL, 8'h85);
        miss(1'b1, 3'h5);
        `CHK(drive_strong_out, 1'b0)
        wr(sgp_pkg::REG_FWD_CTRL, 8'h42);
        miss(1'b0, 3'h0);
        `CHK(drive_strong_out, 1'b1)
        // miss in the cycle right after the write: the new bitmap must already apply
        @(negedge core_clk_in);
        reg_addr_in = sgp_pkg::REG_FWD_CTRL;
        reg_wdata_in = 8'h83;
        reg_wr_in = 1'b1;
        @(negedge core_clk_in);
        reg_wr_in = 1'b0;
        miss_valid_in = 1'b1;
        @(negedge core_clk_in);
        miss_valid_in = 1'b0;
        `CHK(fwd_valid_out, 1'b1)
        `CHK(fwd_override_out, 1'b1)
        `CHK(fwd_ports_out, 3'h3)
        $display("test forwarding done");
    endtask
    // phy address programming, unusable codes and the port 2 address match
    task automatic t_phy;
        miim(5'h01, 2'h1);
        miim(5'h02, 2'h2);
        wr(sgp_pkg::REG_PHY_ADDR, 8'h1f);
        `CHK({phy1_addr_out, phy2_addr_out}, {5'h03, 5'h04})
        rd(sgp_pkg::REG_PHY_ADDR, 8'h18);
        miim(5'h04, 2'h2);
        miim(5'h03, 2'h1);
        miim(5'h05, 2'h0);
        wr(sgp_pkg::REG_PHY_ADDR, 8'h00);
        wr(sgp_pkg::REG_PHY_ADDR, 8'hf0);
        wr(sgp_pkg::REG_PHY_ADDR, 8'hf8);
        rd(sgp_pkg::REG_PHY_ADDR, 8'h18);
        wr(sgp_pkg::REG_PHY_ADDR, 8'he8);
        `CHK({phy1_addr_out, phy2_addr_out}, {5'h1d, 5'h1e})
        $display("test phy address done");
    endtask
    task automatic report_and_stop;
        $display("errors %0d comparisons %0d", err_count, comparisons);
        if (err_count == 0 && comparisons > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask
    // main sequence: reset for four cycles, then each scenario in turn
    initial begin
        repeat (4) @(negedge core_clk_in);
        srst_in = 1'b0;
        t_reset();
        t_remap();
        t_fwd();
        t_phy();
        report_and_stop();
    end
    // a hang is cut short and counted
    initial begin
        #200000;
        err_count++;
        report_and_stop();
    end
endmodule // testbench
